/* File: shared/gpd_defines.vh */
`ifndef GPD_DEFINES_VH
`define GPD_DEFINES_VH

// data register addresses, translated and untranslated views
`define GPD_FIRST_ADDR      32'h04000120
`define GPD_FIRST_ALIAS     32'ha4000120
`define GPD_SECOND_ADDR     32'h04000122
`define GPD_SECOND_ALIAS    32'ha4000122
// serial pin mode register
`define GPD_SMODE_ADDR      32'h04000130
`define GPD_SMODE_ALIAS     32'ha4000130

// reset values
`define GPD_DATA_RST        8'h00
`define GPD_SMODE_RST       16'ha888
`define GPD_RDATA_RST       16'h0000

// per-pin mode codes
`define GPD_MD_OTHER        2'b00
`define GPD_MD_OUT          2'b01
`define GPD_MD_IN_PU        2'b10
`define GPD_MD_IN_NOPU      2'b11

// serial mode field layout: general bit k sits at bits 2k+1:2k
`define GPD_SC_BITS         5
`define GPD_SC_FIELD_W      2

`endif

/* File: rtl/gpd_port8.v */
`timescale 1ns/1ps
`default_nettype none
`include "gpd_defines.vh"

module gpd_port8 #(
    parameter W = 8
) (
    input  wire             clk_sys_i,
    input  wire             srst_i,
    input  wire             ce_i,
    input  wire             wr_en_i,
    input  wire [W-1:0]     wdata_i,
    input  wire [2*W-1:0]   mode_i,
    input  wire [W-1:0]     pin_i,
    output reg  [W-1:0]     rdata_o,
    output reg  [W-1:0]     pin_o,
    output reg  [W-1:0]     pin_oe_o,
    output reg  [W-1:0]     pull_up_o
);

    reg  [W-1:0] data_q;     // stored port data
    reg  [W-1:0] meta_q;     // first sync stage, read by sync_q only
    reg  [W-1:0] sync_q;     // pin levels safe to read
    reg  [W-1:0] oe_d;       // next drive enables
    reg  [W-1:0] pu_d;       // next pull-up enables
    integer      i;

    // data store; only power-on reset clears it, ce low holds it
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            data_q <= `GPD_DATA_RST; // R8
        end else if (ce_i && wr_en_i) begin // R9
            data_q <= wdata_i; // R6
        end
    end

    // two-flop synchroniser on the pin levels
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else if (ce_i) begin
            meta_q <= pin_i;
            sync_q <= meta_q; // R22
        end
    end

    // per-pin decode of drive, pull-up and read source
    always @* begin
        oe_d    = {W{1'b0}};
        pu_d    = {W{1'b0}};
        rdata_o = data_q;
        for (i = 0; i < W; i = i + 1) begin
            oe_d[i] = (mode_i[2*i +: 2] == `GPD_MD_OUT); // R5 R23
            pu_d[i] = (mode_i[2*i +: 2] == `GPD_MD_IN_PU); // R12
            if (mode_i[2*i+1]) begin
                rdata_o[i] = sync_q[i]; // R4
            end else begin
                rdata_o[i] = data_q[i]; // R3
            end
        end
    end

    // pin drivers registered so the pads never glitch
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            pin_o     <= {W{1'b0}};
            pin_oe_o  <= {W{1'b0}};
            pull_up_o <= {W{1'b0}};
        end else if (ce_i) begin
            pin_o     <= data_q;
            pin_oe_o  <= oe_d; // R6
            pull_up_o <= pu_d;
        end
    end

endmodule // gpd_port8

`default_nettype wire

/* File: rtl/gpd_top.v */
// Summary of operation
// R1: first port data register, eight bits RW
// R2: second port data register, eight bits RW
// R3: output mode reads return stored bit
// R4: input modes read the pin level
// R5: output mode drives written data to pin
// R6: other modes store data, pin untouched
// R7: second port behaves like first port
// R8: power-on reset clears both data registers
// R9: standby, sleep, manual reset keep contents
// R10: fixed addresses plus untranslated aliases, byte access
// R11: software uses uncached access to registers
// R12: pull-up set by mode, not data
// R13: plain serial pin fields decode four modes
// R14: channel 1 pair shares transmit and receive
// R15: channel 0 pair uses same pairing
// R16: one general bit spans two pins
// R17: input mode plus transmit enable drives tx
// R18: input mode without transmit enable floats tx
// R19: channel 2 pair uses same pairing
// R20: receive/transmit enables override mode fields
// R21: serial mode register resets, survives manual reset
// R22: pin levels pass two-flop synchroniser
// R23: mode vectors steer drive, read, pull-up
`timescale 1ns/1ps
`default_nettype none
`include "gpd_defines.vh"

module gpd_top #(
    parameter PW = 8,                  // port width
    parameter SB = `GPD_SC_BITS        // serial general bits
) (
    input  wire             clk_sys_i,
    input  wire             srst_i,
    input  wire             ce_i,
    // cpu register access
    input  wire             cpu_sel_i,
    input  wire             cpu_we_i,
    input  wire [31:0]      cpu_addr_i,
    input  wire [15:0]      cpu_wdata_i,
    output reg  [15:0]      cpu_rdata_o,
    output reg              cpu_ack_o,
    // mode vectors from the pin function controller
    input  wire [2*PW-1:0]  first_port_mode_i,
    input  wire [2*PW-1:0]  second_port_mode_i,
    // first port pins
    input  wire [PW-1:0]    first_port_pin_i,
    output wire [PW-1:0]    first_port_pin_o,
    output wire [PW-1:0]    first_port_pin_oe_o,
    output wire [PW-1:0]    first_port_pu_o,
    // second port pins
    input  wire [PW-1:0]    second_port_pin_i,
    output wire [PW-1:0]    second_port_pin_o,
    output wire [PW-1:0]    second_port_pin_oe_o,
    output wire [PW-1:0]    second_port_pu_o,
    // serial controller side, one bit per channel
    input  wire [2:0]       serial_tx_enable_i,
    input  wire [2:0]       serial_rx_enable_i,
    input  wire [2:0]       serial_txd_i,
    output reg  [2:0]       serial_rxd_o,
    // serial general bits, data from and read values to the cpu side
    input  wire [SB-1:0]    serial_gp_bit_i,
    output reg  [SB-1:0]    serial_gp_rd_o,
    // transmit pins of channels 0..2
    output reg  [2:0]       ch_tx_pin_o,
    output reg  [2:0]       ch_tx_pin_oe_o,
    // serial input pins: even k is a receive pin, odd k a plain pin
    input  wire [SB-1:0]    serial_pin_i,
    output reg  [SB-1:0]    serial_pin_o,
    output reg  [SB-1:0]    serial_pin_oe_o,
    output reg  [SB-1:0]    serial_pin_pu_o,
    // serial mode register contents for the rest of the chip
    output reg  [15:0]      serial_port_mode_o
);

    // ------------------------------------------------------------
    // address decode helpers
    // ------------------------------------------------------------

    // true when an address hits either view of a register
    function hit;
        input [31:0] addr;
        input [31:0] phys;
        input [31:0] alias_a;
        begin
            hit = (addr == phys) || (addr == alias_a);
        end
    endfunction

    // serial field of general bit k
    function [1:0] sc_field;
        input [15:0] mode;
        input integer k;
        begin
            sc_field = mode[2*k +: 2];
        end
    endfunction

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------

    wire         acc_w;          // access taken this cycle
    reg          first_hit;      // first port data addressed
    reg          second_hit;     // second port data addressed
    reg          smode_hit;      // serial mode register addressed

    assign acc_w = ce_i && cpu_sel_i;

    // priority chain; each view maps to exactly one register
    always @* begin
        first_hit  = 1'b0;
        second_hit = 1'b0;
        smode_hit  = 1'b0;
        if (hit(cpu_addr_i, `GPD_FIRST_ADDR, `GPD_FIRST_ALIAS)) begin
            first_hit = 1'b1; // R10
        end else if (hit(cpu_addr_i, `GPD_SECOND_ADDR,
                         `GPD_SECOND_ALIAS)) begin
            second_hit = 1'b1; // R10
        end else if (hit(cpu_addr_i, `GPD_SMODE_ADDR,
                         `GPD_SMODE_ALIAS)) begin
            smode_hit = 1'b1;
        end else begin
            first_hit = 1'b0;  // unmapped: acked, reads zero
        end
    end

    wire         first_wr;       // write strobe, first port
    wire         second_wr;      // write strobe, second port

    assign first_wr  = acc_w && cpu_we_i && first_hit;
    assign second_wr = acc_w && cpu_we_i && second_hit;

    // ------------------------------------------------------------
    // the two general ports
    // ------------------------------------------------------------

    wire [PW-1:0] first_rd;      // first port read value
    wire [PW-1:0] second_rd;     // second port read value

    // first port; bit n maps to pin n
    gpd_port8 #(
        .W          (PW)
    ) u_first (
        .clk_sys_i  (clk_sys_i),
        .srst_i     (srst_i),
        .ce_i       (ce_i),
        .wr_en_i    (first_wr), // R1
        .wdata_i    (cpu_wdata_i[PW-1:0]),
        .mode_i     (first_port_mode_i),
        .pin_i      (first_port_pin_i),
        .rdata_o    (first_rd),
        .pin_o      (first_port_pin_o),
        .pin_oe_o   (first_port_pin_oe_o),
        .pull_up_o  (first_port_pu_o)
    );

    // second port; same structure as the first
    gpd_port8 #(
        .W          (PW)
    ) u_second (
        .clk_sys_i  (clk_sys_i),
        .srst_i     (srst_i),
        .ce_i       (ce_i),
        .wr_en_i    (second_wr), // R2 R7
        .wdata_i    (cpu_wdata_i[PW-1:0]),
        .mode_i     (second_port_mode_i),
        .pin_i      (second_port_pin_i),
        .rdata_o    (second_rd),
        .pin_o      (second_port_pin_o),
        .pin_oe_o   (second_port_pin_oe_o),
        .pull_up_o  (second_port_pu_o)
    );

    // ------------------------------------------------------------
    // serial pin mode register
    // ------------------------------------------------------------

    // only power-on reset loads it; ce low holds it in low power
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            serial_port_mode_o <= `GPD_SMODE_RST; // R21
        end else if (acc_w && cpu_we_i && smode_hit) begin
            serial_port_mode_o <= cpu_wdata_i;
        end
    end

    // ------------------------------------------------------------
    // serial pin synchroniser
    // ------------------------------------------------------------

    reg  [SB-1:0] sc_meta_q;     // first stage, read by sc_sync_q only
    reg  [SB-1:0] sc_sync_q;     // synchronised serial pin levels

    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            sc_meta_q <= {SB{1'b0}};
            sc_sync_q <= {SB{1'b0}};
        end else if (ce_i) begin
            sc_meta_q <= serial_pin_i;
            sc_sync_q <= sc_meta_q; // R22
        end
    end

    // ------------------------------------------------------------
    // serial pin decode
    // ------------------------------------------------------------

    reg  [2:0]    tx_d;          // next transmit pin level
    reg  [2:0]    tx_oe_d;       // next transmit pin enable
    reg  [SB-1:0] pin_d;         // next plain pin level
    reg  [SB-1:0] pin_oe_d;      // next plain pin enable
    reg  [SB-1:0] pu_d;          // next pull-up enables
    reg  [SB-1:0] gp_rd_d;       // next general bit read value
    reg  [1:0]    md;            // field under decode
    integer       k;             // general bit index
    integer       ch;            // channel of an even bit

    // even bits are tx/rx pairs, odd bits are plain port pins
    always @* begin
        tx_d     = 3'b000;
        tx_oe_d  = 3'b000;
        pin_d    = {SB{1'b0}};
        pin_oe_d = {SB{1'b0}};
        pu_d     = {SB{1'b0}};
        gp_rd_d  = {SB{1'b0}};
        md       = `GPD_MD_OTHER;
        for (k = 0; k < SB; k = k + 1) begin
            md = sc_field(serial_port_mode_o, k);
            ch = k / 2;
            // read follows the pin only in the input modes
            if (md[1]) begin
                gp_rd_d[k] = sc_sync_q[k]; // R4
            end else begin
                gp_rd_d[k] = serial_gp_bit_i[k]; // R3
            end
            if (k % 2 == 1) begin
                // plain pins: four-way mode decode
                pin_oe_d[k] = (md == `GPD_MD_OUT); // R13
                pin_d[k]    = serial_gp_bit_i[k];
                pu_d[k]     = (md == `GPD_MD_IN_PU); // R13
            end else begin
                // receive pin is never driven; it is input only
                pu_d[k] = (md == `GPD_MD_IN_PU) &&
                          !serial_rx_enable_i[ch]; // R20
                // general bit leaves on tx, enters on rx
                if (serial_tx_enable_i[ch]) begin
                    // serial output beats the mode field
                    tx_oe_d[ch] = 1'b1; // R17 R20
                    tx_d[ch]    = serial_txd_i[ch];
                end else if (md == `GPD_MD_OUT) begin
                    tx_oe_d[ch] = 1'b1; // R14 R15 R19 R16
                    tx_d[ch]    = serial_gp_bit_i[k];
                end else begin
                    // idle serial or port input: tx floats
                    tx_oe_d[ch] = 1'b0; // R18
                    tx_d[ch]    = 1'b0;
                end
            end
        end
    end

    // all serial pin drivers and read values leave from flops
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            ch_tx_pin_o     <= 3'b000;
            ch_tx_pin_oe_o  <= 3'b000;
            serial_pin_o    <= {SB{1'b0}};
            serial_pin_oe_o <= {SB{1'b0}};
            serial_pin_pu_o <= {SB{1'b0}};
            serial_gp_rd_o  <= {SB{1'b0}};
            serial_rxd_o    <= 3'b000;
        end else if (ce_i) begin
            ch_tx_pin_o     <= tx_d;
            ch_tx_pin_oe_o  <= tx_oe_d;
            serial_pin_o    <= pin_d;
            serial_pin_oe_o <= pin_oe_d;
            serial_pin_pu_o <= pu_d;
            serial_gp_rd_o  <= gp_rd_d;
            // receive data always from the rx pins
            serial_rxd_o    <= {sc_sync_q[4], sc_sync_q[2],
                                sc_sync_q[0]}; // R20
        end
    end

    // ------------------------------------------------------------
    // read data and acknowledge
    // ------------------------------------------------------------

    reg  [15:0]   rdata_d;       // read mux output

    // narrow registers sit in the low lanes, upper bits zero
    always @* begin
        rdata_d = `GPD_RDATA_RST;
        if (first_hit) begin
            rdata_d = {8'h00, first_rd}; // R3 R4
        end else if (second_hit) begin
            rdata_d = {8'h00, second_rd};
        end else if (smode_hit) begin
            rdata_d = serial_port_mode_o;
        end else begin
            rdata_d = `GPD_RDATA_RST;
        end
    end

    // one-cycle answer; read data holds until the next read access
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            cpu_rdata_o <= `GPD_RDATA_RST;
            cpu_ack_o   <= 1'b0;
        end else if (ce_i) begin
            cpu_ack_o <= cpu_sel_i;
            if (cpu_sel_i && !cpu_we_i) begin
                cpu_rdata_o <= rdata_d;
            end
        end
    end

endmodule // gpd_top

`default_nettype wire

/* File: test/gpd_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// watches the top's ports; one clock, reset masks every check
module gpd_assertions (
    input wire logic        clk_sys_i,
    input wire logic        srst_i,
    input wire logic        ce_i,
    input wire logic        cpu_sel_i,
    input wire logic        cpu_ack_o,
    input wire logic [15:0] first_port_mode_i,
    input wire logic [7:0]  first_port_pin_o,
    input wire logic [7:0]  first_port_pin_oe_o,
    input wire logic [7:0]  first_port_pu_o,
    input wire logic [2:0]  serial_tx_enable_i,
    input wire logic [2:0]  serial_txd_i,
    input wire logic [4:0]  serial_gp_bit_i,
    input wire logic [2:0]  ch_tx_pin_o,
    input wire logic [2:0]  ch_tx_pin_oe_o,
    input wire logic [15:0] serial_port_mode_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    a_ack_follows: assert property (
        ce_i && cpu_sel_i |=> cpu_ack_o) else $error("ack missing");
    a_ack_quiet: assert property (
        !(ce_i && cpu_sel_i) |=> !cpu_ack_o) else $error("stray ack");
    a_reset_values: assert property (
        $fell(srst_i) |-> first_port_pin_o == 8'h00 && !cpu_ack_o
            && serial_port_mode_o == 16'ha888) else $error("reset value");
    a_out_drive: assert property (
        ce_i && first_port_mode_i[1:0] == 2'b01 |=> first_port_pin_oe_o[0])
        else $error("output mode not driving");
    a_keep_float: assert property (
        ce_i && first_port_mode_i[15:14] != 2'b01 |=> !first_port_pin_oe_o[7])
        else $error("pin driven outside output mode");
    a_pull_up: assert property (
        ce_i && first_port_mode_i[7:6] == 2'b10 |=> first_port_pu_o[3])
        else $error("pull-up off");
    // standby keeps both data and mode contents
    a_freeze_state: assert property (
        !ce_i |=> $stable(first_port_pin_o) && $stable(serial_port_mode_o))
        else $error("state moved while frozen");
    a_tx_enabled: assert property (
        ce_i && serial_tx_enable_i[0] |=> ch_tx_pin_oe_o[0]
            && ch_tx_pin_o[0] == $past(serial_txd_i[0]))
        else $error("tx pin not serial output");
    a_tx_floats: assert property (
        ce_i && !serial_tx_enable_i[1] && serial_port_mode_o[5]
            |=> !ch_tx_pin_oe_o[1]) else $error("tx pin not floating");
    a_gp_output: assert property (
        ce_i && !serial_tx_enable_i[2] && serial_port_mode_o[9:8] == 2'b01
            |=> ch_tx_pin_oe_o[2] && ch_tx_pin_o[2] == $past(serial_gp_bit_i[4]))
        else $error("general bit not on tx pin");
endmodule // gpd_assertions
bind gpd_top gpd_assertions i_chk (.clk_sys_i, .srst_i, .ce_i, .cpu_sel_i,
    .cpu_ack_o, .first_port_mode_i, .first_port_pin_o, .first_port_pin_oe_o,
    .first_port_pu_o, .serial_tx_enable_i, .serial_txd_i, .serial_gp_bit_i,
    .ch_tx_pin_o, .ch_tx_pin_oe_o, .serial_port_mode_o);
`default_nettype wire

/* File: test/gpd_pins.sv */
`timescale 1ns/1ps
`default_nettype none
// board side of one port: the level each pin settles to
module gpd_pins #(parameter int W = 8) (
    input  wire logic         clk_sys_i,
    input  wire logic [W-1:0] drive_i,
    input  wire logic [W-1:0] drive_oe_i,
    input  wire logic [W-1:0] pull_up_i,
    input  wire logic [W-1:0] ext_en_i,
    input  wire logic [W-1:0] ext_val_i,
    output var  logic [W-1:0] level_o
);
    logic [W-1:0] noise_q = '0; // floating pins wander every cycle
    always @(posedge clk_sys_i) noise_q <= ~noise_q;
    always_comb begin
        for (int n = 0; n < W; n++) begin
            if (drive_oe_i[n]) level_o[n] = drive_i[n];
            else if (ext_en_i[n]) level_o[n] = ext_val_i[n];
            else if (pull_up_i[n]) level_o[n] = 1'b1;
            else level_o[n] = noise_q[n];
        end
    end
endmodule // gpd_pins
`default_nettype wire

/* File: test/gpd_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
    $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module gpd_top_test;
    logic clk_sys_i = 0, srst_i = 1, ce_i = 1, cpu_sel_i = 0, cpu_we_i = 0;
    logic cpu_ack_o, te, ok, po, pp, pe;
    logic [1:0] md;
    logic [31:0] cpu_addr_i = '0;
    logic [15:0] cpu_wdata_i = '0, cpu_rdata_o, serial_port_mode_o, sm;
    logic [15:0] first_port_mode_i = '0, second_port_mode_i = '0;
    logic [7:0] first_port_pin_i, first_port_pin_o, first_port_pin_oe_o;
    logic [7:0] second_port_pin_i, second_port_pin_o, second_port_pin_oe_o;
    logic [7:0] first_port_pu_o, second_port_pu_o, ea, eb, da, db, ra, rb;
    logic [7:0] ext_en_a = '0, ext_en_b = '0;
    logic [2:0] serial_tx_enable_i = '0, serial_rx_enable_i = '0, et;
    logic [2:0] serial_txd_i = '0, serial_rxd_o, ch_tx_pin_o, ch_tx_pin_oe_o;
    logic [4:0] serial_gp_bit_i = '0, serial_pin_i = '0, serial_gp_rd_o;
    logic [4:0] serial_pin_o, serial_pin_oe_o, serial_pin_pu_o;
    logic [16:0] exp_q[$]; // bit 16 set: compare read data
    logic [16:0] exp_e;
    int n_errors = 0, tests_run = 0;
    initial forever #5 clk_sys_i = ~clk_sys_i;
    gpd_top i_dut (.clk_sys_i, .srst_i, .ce_i, .cpu_sel_i, .cpu_we_i,
        .cpu_addr_i, .cpu_wdata_i, .cpu_rdata_o, .cpu_ack_o,
        .first_port_mode_i, .second_port_mode_i, .first_port_pin_i,
        .first_port_pin_o, .first_port_pin_oe_o, .first_port_pu_o,
        .second_port_pin_i, .second_port_pin_o, .second_port_pin_oe_o,
        .second_port_pu_o, .serial_tx_enable_i, .serial_rx_enable_i,
        .serial_txd_i, .serial_rxd_o, .serial_gp_bit_i, .serial_gp_rd_o,
        .ch_tx_pin_o, .ch_tx_pin_oe_o, .serial_pin_i, .serial_pin_o,
        .serial_pin_oe_o, .serial_pin_pu_o, .serial_port_mode_o);
    gpd_pins i_pins_a (.clk_sys_i, .drive_i(first_port_pin_o),
        .drive_oe_i(first_port_pin_oe_o), .pull_up_i(first_port_pu_o),
        .ext_en_i(ext_en_a), .ext_val_i(ea), .level_o(first_port_pin_i));
    gpd_pins i_pins_b (.clk_sys_i, .drive_i(second_port_pin_o),
        .drive_oe_i(second_port_pin_oe_o), .pull_up_i(second_port_pu_o),
        .ext_en_i(ext_en_b), .ext_val_i(eb), .level_o(second_port_pin_i));
    task automatic finish_test();
        if (n_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    // one access; every ack owes one queue entry
    task automatic access(input logic we, input logic [31:0] a,
                          input logic [15:0] d, input logic [15:0] e);
        tick(1);
        cpu_sel_i = 1;
        cpu_we_i = we;
        cpu_addr_i = a;
        cpu_wdata_i = d;
        exp_q.push_back({~we, e});
        tick(1);
        cpu_sel_i = 0;
    endtask
    // ack watcher: oldest note against the returned data
    always @(posedge clk_sys_i) begin
        if (cpu_ack_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("unexpected ack at %0t: %h vs %h", $time,
                         cpu_rdata_o, 16'h0000);
            end else begin
                exp_e = exp_q.pop_front();
                if (exp_e[16]) `CHK(cpu_rdata_o, exp_e[15:0])
            end
        end
    end
    initial begin
        #50000;
        n_errors++;
        finish_test();
    end
    initial begin
        void'($urandom(29));
        tick(5);
        srst_i = 0;
        access(0, 32'h04000120, 16'h0000, 16'h0000);
        access(0, 32'ha4000122, 16'h0000, 16'h0000);
        access(0, 32'h04000130, 16'h0000, 16'ha888);
        access(1, 32'h04000124, 16'h00ff, 16'h0000);
        access(0, 32'h04000124, 16'h0000, 16'h0000);
        // every mode code on both ports, board drives only mode 11
        for (int c = 0; c < 4; c++) begin
            md = c[1:0];
            da = 8'($urandom);
            db = 8'($urandom);
            ea = 8'($urandom);
            eb = ~ea;
            first_port_mode_i = {8{md}};
            second_port_mode_i = {8{md}};
            ext_en_a = {8{md == 2'b11}};
            ext_en_b = ext_en_a;
            access(1, c[0] ? 32'ha4000120 : 32'h04000120, {8'hff, da}, 16'h0);
            access(1, 32'h04000122, {8'h5a, db}, 16'h0000);
            tick(3);
            ra = md[1] ? (md[0] ? ea : 8'hff) : da;
            rb = md[1] ? (md[0] ? eb : 8'hff) : db;
            access(0, 32'h04000120, 16'h0000, {8'h00, ra});
            access(0, 32'ha4000122, 16'h0000, {8'h00, rb});
            `CHK(first_port_pin_oe_o, {8{md == 2'b01}})
            `CHK(second_port_pu_o, {8{md == 2'b10}})
            `CHK(second_port_pin_oe_o, {8{md == 2'b01}})
            `CHK(first_port_pu_o, {8{md == 2'b10}})
            if (md == 2'b01)
                `CHK({first_port_pin_o, second_port_pin_o}, {da, db})
        end
        // standby: a request while frozen is not taken
        first_port_mode_i = 16'h0000;
        tick(2);
        ce_i = 0;
        cpu_sel_i = 1;
        cpu_we_i = 1;
        cpu_addr_i = 32'h04000120;
        cpu_wdata_i = 16'h003c;
        tick(4);
        cpu_sel_i = 0;
        ce_i = 1;
        access(0, 32'h04000120, 16'h0000, {8'h00, da});
        // serial pairs: all four codes, transmit enable off and on
        for (int c = 0; c < 8; c++) begin
            md = c[1:0];
            te = c[2];
            sm = {6'h00, {5{md}}};
            access(1, 32'ha4000130, sm, 16'h0000);
            serial_tx_enable_i = {3{te}};
            serial_rx_enable_i = {3{c[2] ^ c[1]}};
            serial_txd_i = 3'($urandom);
            serial_gp_bit_i = 5'($urandom);
            serial_pin_i = 5'($urandom);
            tick(4);
            ok = te | (md == 2'b01);
            po = md == 2'b01;
            pp = md == 2'b10;
            pe = pp & ~serial_rx_enable_i[0];
            et = {serial_gp_bit_i[4], serial_gp_bit_i[2], serial_gp_bit_i[0]};
            if (te) et = serial_txd_i;
            `CHK(ch_tx_pin_oe_o, {3{ok}})
            if (ok) `CHK(ch_tx_pin_o, et)
            `CHK(serial_pin_oe_o, {1'b0, po, 1'b0, po, 1'b0})
            if (po) `CHK(serial_pin_o & 5'h0a, serial_gp_bit_i & 5'h0a)
            `CHK(serial_pin_pu_o, {pe, pp, pe, pp, pe})
            et = {serial_pin_i[4], serial_pin_i[2], serial_pin_i[0]};
            `CHK(serial_rxd_o, et)
            `CHK(serial_gp_rd_o, md[1] ? serial_pin_i : serial_gp_bit_i)
            access(0, 32'h04000130, 16'h0000, sm);
        end
        // second power-on reset in mid-run
        access(1, 32'h04000120, 16'h00a5, 16'h0000);
        srst_i = 1;
        tick(2);
        srst_i = 0;
        access(0, 32'ha4000120, 16'h0000, 16'h0000);
        access(0, 32'ha4000130, 16'h0000, 16'ha888);
        tick(3);
        if (exp_q.size() != 0) begin
            n_errors++;
            $display("unexpected at %0t: %h vs %h", $time, exp_q.size(), 0);
        end
        finish_test();
    end
endmodule // gpd_top_test
`default_nettype wire
